// File: hdl/dmo_defines.svh
`ifndef DMO_DEFINES_SVH
`define DMO_DEFINES_SVH

// register byte addresses
`define DMO_ADDR_STATE_OVR      8'h32
`define DMO_ADDR_REF_FORCE      8'h34
`define DMO_ADDR_STATUS         8'h38

// field widths
`define DMO_FORCE_CODE_W        3
`define DMO_REF_SEL_W           4

// reset values
`define DMO_STATE_OVR_RST       3'h0
`define DMO_REF_FORCE_RST       4'hF

// force codes
`define DMO_CODE_AUTO           3'h0
`define DMO_CODE_FREE_RUN       3'h1
`define DMO_CODE_HOLDOVER       3'h2
`define DMO_CODE_UNUSED         3'h3
`define DMO_CODE_LOCKED         3'h4
`define DMO_CODE_PRE_LOCKED2    3'h5
`define DMO_CODE_PRE_LOCKED     3'h6
`define DMO_CODE_PHASE_LOST     3'h7

`endif

// File: hdl/dmo_pkg.sv
package dmo_pkg;

   typedef enum logic [2:0] {
      DMO_ST_FREE_RUN,
      DMO_ST_HOLDOVER,
      DMO_ST_LOCKED,
      DMO_ST_PRE_LOCKED,
      DMO_ST_PRE_LOCKED2,
      DMO_ST_PHASE_LOST
   } dmo_state_t;

   typedef struct packed {
      logic [2:0] force_code;
      logic [3:0] ref_sel;
      logic [31:0] rdata;
      logic        slverr;
   } dmo_regs_t;

   typedef struct packed {
      dmo_state_t state;
   } dmo_fsm_t;

endpackage

// File: hdl/dmo_state_core.sv
`timescale 1ns/1ps
`include "dmo_defines.svh"

module dmo_state_core
   import dmo_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic [2:0] force_code_in,
   input  wire logic       mon_ref_ok_in,
   input  wire logic       mon_locked_in,
   input  wire logic       mon_phase_err_in,
   output dmo_state_t      state_out
);

   dmo_fsm_t st_r;
   dmo_fsm_t st_nxt;
   dmo_state_t auto_nxt;

   // automatic walk driven only by the monitor inputs
   always_comb begin
      auto_nxt = st_r.state;
      unique case (st_r.state)
         DMO_ST_FREE_RUN:    if (mon_ref_ok_in) auto_nxt = DMO_ST_PRE_LOCKED;
         DMO_ST_PRE_LOCKED: begin
            if (!mon_ref_ok_in) auto_nxt = DMO_ST_FREE_RUN;
            else if (mon_locked_in) auto_nxt = DMO_ST_LOCKED;
         end
         DMO_ST_LOCKED: begin
            if (!mon_ref_ok_in) auto_nxt = DMO_ST_HOLDOVER;
            else if (mon_phase_err_in) auto_nxt = DMO_ST_PHASE_LOST;
         end
         DMO_ST_PHASE_LOST: begin
            if (!mon_ref_ok_in) auto_nxt = DMO_ST_HOLDOVER;
            else if (!mon_phase_err_in) auto_nxt = DMO_ST_LOCKED;
         end
         DMO_ST_HOLDOVER:    if (mon_ref_ok_in) auto_nxt = DMO_ST_PRE_LOCKED2;
         DMO_ST_PRE_LOCKED2: begin
            if (!mon_ref_ok_in) auto_nxt = DMO_ST_HOLDOVER;
            else if (mon_locked_in) auto_nxt = DMO_ST_LOCKED;
         end
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      // monitors ignored whenever a state is forced
      unique case (force_code_in)
         `DMO_CODE_AUTO:        st_nxt.state = auto_nxt;           // see R1
         `DMO_CODE_FREE_RUN:    st_nxt.state = DMO_ST_FREE_RUN;    // see R2 see R4
         `DMO_CODE_HOLDOVER:    st_nxt.state = DMO_ST_HOLDOVER;    // see R2 see R4
         `DMO_CODE_UNUSED:      st_nxt.state = st_r.state;         // see R2
         `DMO_CODE_LOCKED:      st_nxt.state = DMO_ST_LOCKED;      // see R2 see R4
         `DMO_CODE_PRE_LOCKED2: st_nxt.state = DMO_ST_PRE_LOCKED2; // see R3 see R4
         `DMO_CODE_PRE_LOCKED:  st_nxt.state = DMO_ST_PRE_LOCKED;  // see R3 see R4
         `DMO_CODE_PHASE_LOST:  st_nxt.state = DMO_ST_PHASE_LOST;  // see R3 see R4
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r.state <= DMO_ST_FREE_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign state_out = st_r.state;

endmodule

// File: hdl/dmo_mode_override.sv
// How it works
// R1: code 000 leaves the automatic state machine in charge of the pll state.
// R2: codes 001, 010, 100 force free run, holdover, locked; 011 unused.
// R3: codes 101, 110, 111 force pre-locked2, pre-locked, phase lost.
// R4: while a state is forced, monitor inputs cannot change the state.
// R5: software forcing a state must do the monitoring and control itself.
// R6: override register is read/write, code in bits 2:0, bits 7:3 unused.
// R7: reference force register is read/write, bits 7:4 unused.
// R8: unused bits read as zero and ignore writes.
`timescale 1ns/1ps
`include "dmo_defines.svh"

module dmo_mode_override
   import dmo_pkg::*;
(
   input  wire logic        SYS_CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic        PSEL_IN,
   input  wire logic        PENABLE_IN,
   input  wire logic        PWRITE_IN,
   input  wire logic [7:0]  PADDR_IN,
   input  wire logic [31:0] PWDATA_IN,
   input  wire logic [3:0]  PSTRB_IN,
   output logic [31:0]      PRDATA_OUT,
   output logic             PREADY_OUT,
   output logic             PSLVERR_OUT,
   input  wire logic        MON_REF_OK_IN,
   input  wire logic        MON_LOCKED_IN,
   input  wire logic        MON_PHASE_ERR_IN,
   output logic [2:0]       PLL_STATE_OUT,
   output logic [3:0]       REF_FORCE_SEL_OUT,
   output logic             STATE_FORCED_OUT
);

   dmo_regs_t  reg_r;
   dmo_regs_t  reg_nxt;
   dmo_state_t core_state;
   logic [2:0] mon_s1_r;
   logic [2:0] mon_s2_r;
   logic       setup_ok;
   logic       acc_wr;
   logic       rd_setup;

   // monitor inputs come from outside, two flops first
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         mon_s1_r <= 3'h0;
         mon_s2_r <= 3'h0;
      end else begin
         mon_s1_r <= {MON_PHASE_ERR_IN, MON_LOCKED_IN, MON_REF_OK_IN};
         mon_s2_r <= mon_s1_r;
      end
   end

   assign setup_ok = PSEL_IN && PENABLE_IN;
   assign acc_wr   = setup_ok && PWRITE_IN;
   assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;

   always_comb begin
      reg_nxt = reg_r;
      reg_nxt.slverr = 1'b0;
      if (acc_wr) begin
         unique case (PADDR_IN)
            `DMO_ADDR_STATE_OVR: begin
               // upper bits dropped on write
               if (PSTRB_IN[0]) reg_nxt.force_code = PWDATA_IN[2:0];  // see R6 see R8
            end
            `DMO_ADDR_REF_FORCE: begin
               if (PSTRB_IN[0]) reg_nxt.ref_sel = PWDATA_IN[3:0];     // see R7 see R8
            end
            default: reg_nxt.slverr = 1'b1;
         endcase
      end
      // loaded in setup so the word stands through the access edge
      if (rd_setup) begin
         unique case (PADDR_IN)
            `DMO_ADDR_STATE_OVR: reg_nxt.rdata = {29'h0, reg_r.force_code}; // see R6 see R8
            `DMO_ADDR_REF_FORCE: reg_nxt.rdata = {28'h0, reg_r.ref_sel};    // see R7 see R8
            `DMO_ADDR_STATUS:    reg_nxt.rdata = {28'h0,
                                                  (reg_r.force_code != `DMO_CODE_AUTO),
                                                  core_state};
            default: begin
               reg_nxt.rdata  = 32'h0000_0000;
               reg_nxt.slverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         reg_r.force_code <= `DMO_STATE_OVR_RST;
         reg_r.ref_sel    <= `DMO_REF_FORCE_RST;
         reg_r.rdata      <= 32'h0000_0000;
         reg_r.slverr     <= 1'b0;
      end else begin
         reg_r <= reg_nxt;
      end
   end

   // state machine sees the live register code, monitors already synced
   dmo_state_core u_core (
      .clk_in           (SYS_CLK_IN),
      .rst_n_in         (RESETN_IN),
      .force_code_in    (reg_r.force_code),
      .mon_ref_ok_in    (mon_s2_r[0]),
      .mon_locked_in    (mon_s2_r[1]),
      .mon_phase_err_in (mon_s2_r[2]),
      .state_out        (core_state)
   );

   // zero-wait slave keeps the bus simple; read data is registered in setup
   assign PREADY_OUT        = 1'b1;
   assign PRDATA_OUT        = reg_r.rdata;
   assign PSLVERR_OUT       = setup_ok && (PADDR_IN != `DMO_ADDR_STATE_OVR)
                              && (PADDR_IN != `DMO_ADDR_REF_FORCE)
                              && !(!PWRITE_IN && PADDR_IN == `DMO_ADDR_STATUS);
   assign PLL_STATE_OUT     = core_state;
   assign REF_FORCE_SEL_OUT = reg_r.ref_sel;
   assign STATE_FORCED_OUT  = (reg_r.force_code != `DMO_CODE_AUTO); // see R4

endmodule

// File: tb/dmo_mode_override_sva.sv
`timescale 1ns/1ps
`include "dmo_defines.svh"
module dmo_mode_override_sva
   import dmo_pkg::*;
(
   input wire logic        SYS_CLK_IN,
   input wire logic        RESETN_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [7:0]  PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic [2:0]  PLL_STATE_OUT,
   input wire logic [3:0]  REF_FORCE_SEL_OUT,
   input wire logic        STATE_FORCED_OUT
);
   localparam logic [2:0] MAP [8] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h2, 3'h4, 3'h3, 3'h5};
   logic [2:0] code_r;
   logic [3:0] ref_r;
   logic [1:0] age_r;
   wire logic  acc = PSEL_IN & PENABLE_IN;
   wire logic  ovr = acc && PADDR_IN == `DMO_ADDR_STATE_OVR;
   wire logic  rfs = acc && PADDR_IN == `DMO_ADDR_REF_FORCE;
   // age saturates: only settled forced states are judged
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         code_r <= 3'h0;
         ref_r  <= 4'hF;
         age_r  <= 2'h0;
      end else begin
         if (ovr && PWRITE_IN) code_r <= PWDATA_IN[2:0];
         if (rfs && PWRITE_IN) ref_r <= PWDATA_IN[3:0];
         age_r <= (ovr && PWRITE_IN) ? 2'h0 : age_r + {1'b0, ~&age_r};
      end
   end
   sequence s_rd_ovr; ovr && !PWRITE_IN; endsequence
   sequence s_rd_ref; rfs && !PWRITE_IN; endsequence
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   a_forced_flag: assert property (STATE_FORCED_OUT == (code_r != 3'h0))
      else $error("forced flag");
   a_state_map: assert property (age_r[1] && code_r != 3'h0 && code_r != 3'h3
      |-> PLL_STATE_OUT == MAP[code_r]) else $error("state map");
   a_forced_hold: assert property (STATE_FORCED_OUT && &age_r
      |-> $stable(PLL_STATE_OUT)) else $error("state moved");
   a_read_ovr: assert property (s_rd_ovr |-> PRDATA_OUT == {29'h0, code_r})
      else $error("override read");
   a_read_ref: assert property (s_rd_ref |-> PRDATA_OUT == {28'h0, ref_r})
      else $error("ref read");
   a_ref_out: assert property (REF_FORCE_SEL_OUT == ref_r)
      else $error("ref out");
   a_err_unmap: assert property (acc && !(ovr || rfs) && PADDR_IN != `DMO_ADDR_STATUS
      |-> PSLVERR_OUT) else $error("no error");
   a_no_err: assert property (ovr || rfs |-> !PSLVERR_OUT)
      else $error("bad error");
endmodule

// File: tb/test_dmo_mode_override.sv
`timescale 1ns/1ps
`include "dmo_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch %0t %h %h", $time, g, e); end end
module test_dmo_mode_override;
   localparam logic [2:0] EXP [8] = '{3'h0, 3'h0, 3'h1, 3'h0, 3'h2, 3'h4, 3'h3, 3'h5};
   logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, err, forced, er;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, prd, rd, r;
   logic [3:0]  refsel;
   logic [2:0]  mon = 3'h0, pll, c, prv;
   int          fail_count = 0, n_compared = 0, cyc = 0;
   always #10 clk = ~clk;
   dmo_mode_override uut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(adr), .PWDATA_IN(wd), .PSTRB_IN(4'hF),
      .PRDATA_OUT(prd), .PREADY_OUT(pready), .PSLVERR_OUT(err), .MON_REF_OK_IN(mon[0]),
      .MON_LOCKED_IN(mon[1]), .MON_PHASE_ERR_IN(mon[2]), .PLL_STATE_OUT(pll),
      .REF_FORCE_SEL_OUT(refsel), .STATE_FORCED_OUT(forced));
   function automatic logic [2:0] exp_st(input logic [2:0] k);
      return EXP[k];
   endfunction
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // read data and error are taken at the edge where pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr  <= w;
      adr  <= a;
      wd   <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      er = err;
      rd = prd;
      psel <= 1'b0;
      pen  <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      r = $urandom(32'h065f);
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, `DMO_ADDR_STATE_OVR, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, `DMO_ADDR_REF_FORCE, 32'h0);
      `CHK(rd, 32'hF)
      apb(1'b0, 8'h40, 32'h0);
      `CHK(er, 1'b1)
      `CHK(rd, 32'h0)
      apb(1'b1, `DMO_ADDR_STATUS, 32'hFFFF_FFFF);
      `CHK(er, 1'b1)
      `CHK(forced, 1'b0)
      $display("reset test done");
      for (int i = 0; i < 16; i++) begin
         c = (i < 8) ? 3'(i) : 3'($urandom);
         r = $urandom;
         apb(1'b1, `DMO_ADDR_STATE_OVR, {r[31:3], c});
         @(negedge clk);
         prv = pll;
         repeat (4) begin
            @(posedge clk);
            mon <= 3'($urandom);
         end
         @(negedge clk);
         `CHK(forced, c != 3'h0)
         if (c == 3'h3) `CHK(pll, prv)
         else if (c != 3'h0) `CHK(pll, exp_st(c))
         @(posedge clk);
         apb(1'b0, `DMO_ADDR_STATE_OVR, 32'h0);
         `CHK(rd, {29'h0, c})
         apb(1'b1, `DMO_ADDR_REF_FORCE, r);
         apb(1'b0, `DMO_ADDR_REF_FORCE, 32'h0);
         `CHK(rd, {28'h0, r[3:0]})
         `CHK(refsel, r[3:0])
         apb(1'b0, `DMO_ADDR_STATUS, 32'h0);
         `CHK(rd, {28'h0, c != 3'h0, pll})
      end
      $display("force code test done");
      rst_n <= 1'b0;
      mon   <= 3'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK(forced, 1'b0)
      `CHK(pll, 3'h0)
      @(posedge clk);
      apb(1'b0, `DMO_ADDR_STATE_OVR, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, `DMO_ADDR_REF_FORCE, 32'h0);
      `CHK(rd, 32'hF)
      $display("mid-run reset test done");
      complete_run();
   end
endmodule
bind dmo_mode_override dmo_mode_override_sva chk (.*);
